// ==== bbiow_pkg.sv ====
/*
 * Constants for the bridge bus number, I/O window and downstream-side
 * error flag register bank: register offsets, field positions, reset
 * values, flag layout and bus handshake states.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
`default_nettype none

package bbiow_pkg;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam int unsigned BBIOW_ADDR_W = 8;
   localparam logic [7:0] BBIOW_OFF_BUS = 8'h18;
   localparam logic [7:0] BBIOW_OFF_IO_STAT = 8'h1c;
   localparam logic [7:0] BBIOW_OFF_IO_UPPER = 8'h30;
   localparam logic [7:0] BBIOW_OFF_CTRL = 8'h3c;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int unsigned BBIOW_SEC_BUS_LSB = 8;
   localparam int unsigned BBIOW_SUB_BUS_LSB = 16;
   localparam int unsigned BBIOW_LAT_LSB = 24;
   localparam int unsigned BBIOW_IO_BASE_CAP_LSB = 0;
   localparam int unsigned BBIOW_IO_BASE_LSB = 4;
   localparam int unsigned BBIOW_IO_LIM_CAP_LSB = 8;
   localparam int unsigned BBIOW_IO_LIM_LSB = 12;
   localparam int unsigned BBIOW_UP_BASE_LSB = 0;
   localparam int unsigned BBIOW_UP_LIM_LSB = 16;
   localparam int unsigned BBIOW_CTRL_PERR_EN = 0;
   localparam int unsigned BBIOW_CTRL_SYS_ERR_EN = 1;
   localparam int unsigned BBIOW_STAT_BYTE = 3;

   // ------------------------------------------------------------
   // Field values and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] BBIOW_BUS_RST = 8'h00;
   localparam logic [7:0] BBIOW_LAT_VAL = 8'h00;
   localparam logic [3:0] BBIOW_IO_CAP_VAL = 4'h1;
   localparam logic [3:0] BBIOW_IO_NIB_RST = 4'h0;
   localparam logic [15:0] BBIOW_UPPER_RST = 16'h0000;
   localparam logic [1:0] BBIOW_CTRL_RST = 2'h0;
   localparam logic [11:0] BBIOW_IO_BASE_LOW = 12'h000;
   localparam logic [11:0] BBIOW_IO_LIM_LOW = 12'hfff;
   localparam logic [31:0] BBIOW_ZERO_WORD = 32'h0000_0000;

   // ------------------------------------------------------------
   // Error flag layout: index order, bit position, clear style
   // ------------------------------------------------------------
   localparam int unsigned BBIOW_NFLAG = 6;
   localparam int unsigned BBIOW_FLAG_POS [BBIOW_NFLAG] =
      '{24, 27, 28, 29, 30, 31};
   // One marks a flag that software clears by writing one
   localparam logic [5:0] BBIOW_FLAG_W1C = 6'h31;
   localparam logic [5:0] BBIOW_FLAG_RST = 6'h00;

   // ------------------------------------------------------------
   // Bus handshake states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      BBIOW_ST_IDLE = 2'b01,
      BBIOW_ST_RESP = 2'b10
   } bbiow_state_t;

endpackage : bbiow_pkg

`default_nettype wire

// ==== bbiow_io_match.sv ====
/*
 * I/O window comparator: composes the full 32-bit lower and upper
 * window bounds and tells whether an address lies inside them.
 * Assumes the caller registers the result; purely combinational.
 */
`default_nettype none

module bbiow_io_match (
   // Window settings
   input wire logic [15:0] base_upper,
   input wire logic [3:0] base_nib,
   input wire logic [15:0] limit_upper,
   input wire logic [3:0] limit_nib,
   // Address under test
   input wire logic [31:0] addr,
   // Result
   output logic hit
);
   import bbiow_pkg::*;

   logic [31:0] lower_bound;
   logic [31:0] upper_bound;

   // Compose bounds: low bits zero below, all ones above
   always_comb begin
      lower_bound = {base_upper, base_nib, BBIOW_IO_BASE_LOW}; // see R05 R08
      upper_bound = {limit_upper, limit_nib, BBIOW_IO_LIM_LOW}; // see R06 R08
      hit = (addr >= lower_bound) && (addr <= upper_bound); // see R18
   end

endmodule : bbiow_io_match

`default_nettype wire

// ==== bbiow_top.sv ====
/*
 * Bridge bus number, I/O window and downstream-side error flag bank.
 * Holds the bus range bytes, the I/O window fields and the sticky
 * error flags, answers APB register accesses, and decides I/O
 * forwarding and bus range membership.
 * Assumes single-clock surroundings: all event and request inputs come
 * from logic on pclk and need no synchroniser.
 */
// Overview of operation
// R01 - Bits 23:16 hold highest downstream bus number, read-write, reset zero.
// R02 - Software programs highest downstream bus number during enumeration.
// R03 - Latency byte bits 31:24 reads zero; writes ignored.
// R04 - I/O base 3:0 and limit 11:8 read one: 32-bit I/O.
// R05 - Bits 7:4 give lower bound address 15:12; low twelve bits zero.
// R06 - Bits 15:12 give upper bound address 15:12; low bits all ones.
// R07 - I/O base and limit decide whether I/O transactions are passed.
// R08 - Bound bits 31:16 come from separate upper-half registers.
// R09 - 66 MHz, fast back-to-back and select timing bits read zero.
// R10 - Bit 24 sets on downstream parity error; write one clears.
// R11 - Bit 24 never sets while parity error response is disabled.
// R12 - Bit 27 sets when completing a request with completer abort.
// R13 - Bit 28 sets on received completion with completer abort.
// R14 - Bit 29 sets on received completion with unsupported request.
// R15 - Bit 30 sets on sent fatal/nonfatal message with error reporting.
// R16 - Bit 31 sets on received poisoned packet; write one clears.
// R17 - Bits 15:8 hold secondary bus number, read-write, reset zero.
// R18 - Forward I/O only when address lies between composed bounds.
// R19 - Reserved status bits read zero; writes to read-only bits ignored.
`default_nettype none

module bbiow_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB register port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [bbiow_pkg::BBIOW_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Downstream-side error events, one-cycle pulses
   input wire logic sec_parity_err_evt,
   input wire logic sec_cpl_abort_sent_evt,
   input wire logic sec_rx_cpl_abort_evt,
   input wire logic sec_rx_cpl_ur_evt,
   input wire logic err_msg_sent_evt,
   input wire logic sec_poisoned_rx_evt,
   // I/O forwarding check
   input wire logic io_req_valid,
   input wire logic [31:0] io_req_addr,
   output logic io_fwd_valid,
   output logic io_fwd_hit,
   // Bus number range check
   input wire logic bus_req_valid,
   input wire logic [7:0] bus_req_num,
   output logic bus_range_valid,
   output logic bus_in_range
);
   import bbiow_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   bbiow_state_t state_q, state_d;
   logic [31:0] prdata_q, prdata_d;
   logic pslverr_q, pslverr_d, pready_q, pready_d;
   logic [7:0] sec_bus_q, sec_bus_d;
   logic [7:0] sub_bus_q, sub_bus_d;
   logic [3:0] io_base_q, io_base_d;
   logic [3:0] io_lim_q, io_lim_d;
   logic [15:0] up_base_q, up_base_d;
   logic [15:0] up_lim_q, up_lim_d;
   logic [1:0] ctrl_q, ctrl_d;
   logic [5:0] flag_q, flag_d;
   logic [5:0] flag_set, flag_clr;
   logic io_fwd_valid_q, io_fwd_valid_d;
   logic io_fwd_hit_q, io_fwd_hit_d;
   logic bus_valid_q, bus_valid_d;
   logic bus_in_q, bus_in_d;
   logic io_hit_raw;
   logic acc_done, wr_en, addr_ok;
   logic [31:0] rd_word;

   // ------------------------------------------------------------
   // APB handshake
   // ------------------------------------------------------------

   // Access completes on the edge where the slave shows ready
   assign acc_done = psel && penable && (state_q == BBIOW_ST_RESP);
   assign wr_en = acc_done && pwrite;

   // Address decode of the mapped words
   always_comb begin
      case (paddr)
         BBIOW_OFF_BUS: addr_ok = 1'b1;
         BBIOW_OFF_IO_STAT: addr_ok = 1'b1;
         BBIOW_OFF_IO_UPPER: addr_ok = 1'b1;
         BBIOW_OFF_CTRL: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Read data assembly; constant and reserved fields read fixed values
   always_comb begin
      rd_word = BBIOW_ZERO_WORD;
      case (paddr)
         BBIOW_OFF_BUS: begin
            rd_word[BBIOW_SEC_BUS_LSB +: 8] = sec_bus_q; // see R17
            rd_word[BBIOW_SUB_BUS_LSB +: 8] = sub_bus_q; // see R01
            rd_word[BBIOW_LAT_LSB +: 8] = BBIOW_LAT_VAL; // see R03
         end
         BBIOW_OFF_IO_STAT: begin
            rd_word[BBIOW_IO_BASE_CAP_LSB +: 4] = BBIOW_IO_CAP_VAL; // see R04
            rd_word[BBIOW_IO_BASE_LSB +: 4] = io_base_q;
            rd_word[BBIOW_IO_LIM_CAP_LSB +: 4] = BBIOW_IO_CAP_VAL; // see R04
            rd_word[BBIOW_IO_LIM_LSB +: 4] = io_lim_q;
            // Bits 26:16 other than flags stay zero, see R09 R19
            for (int i = 0; i < BBIOW_NFLAG; i++) begin
               rd_word[BBIOW_FLAG_POS[i]] = flag_q[i];
            end
         end
         BBIOW_OFF_IO_UPPER: begin
            rd_word[BBIOW_UP_BASE_LSB +: 16] = up_base_q;
            rd_word[BBIOW_UP_LIM_LSB +: 16] = up_lim_q;
         end
         BBIOW_OFF_CTRL: begin
            rd_word[BBIOW_CTRL_PERR_EN +: 2] = ctrl_q;
         end
         default: rd_word = BBIOW_ZERO_WORD;
      endcase
   end

   // Next state: one wait cycle, then ready with data and error
   always_comb begin
      state_d = state_q;
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      pready_d = 1'b0;
      case (state_q)
         BBIOW_ST_IDLE: begin
            if (psel && penable) begin
               state_d = BBIOW_ST_RESP;
               pready_d = 1'b1;
               prdata_d = pwrite ? BBIOW_ZERO_WORD : rd_word;
               pslverr_d = !addr_ok;
            end
         end
         BBIOW_ST_RESP: begin
            state_d = BBIOW_ST_IDLE;
            prdata_d = BBIOW_ZERO_WORD;
         end
         default: begin
            state_d = BBIOW_ST_IDLE;
            prdata_d = BBIOW_ZERO_WORD;
         end
      endcase
   end

   // Handshake registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= BBIOW_ST_IDLE;
         prdata_q <= BBIOW_ZERO_WORD;
         pslverr_q <= 1'b0;
         pready_q <= 1'b0;
      end else begin
         state_q <= state_d;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
         pready_q <= pready_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ------------------------------------------------------------
   // Configuration fields
   // ------------------------------------------------------------

   // Byte-lane writes; read-only bytes and nibbles have no storage
   always_comb begin
      sec_bus_d = sec_bus_q;
      sub_bus_d = sub_bus_q;
      io_base_d = io_base_q;
      io_lim_d = io_lim_q;
      up_base_d = up_base_q;
      up_lim_d = up_lim_q;
      ctrl_d = ctrl_q;
      if (wr_en) begin
         case (paddr)
            BBIOW_OFF_BUS: begin
               if (pstrb[1]) begin
                  sec_bus_d = pwdata[BBIOW_SEC_BUS_LSB +: 8]; // see R17
               end
               if (pstrb[2]) begin
                  sub_bus_d = pwdata[BBIOW_SUB_BUS_LSB +: 8]; // see R01 R02
               end
               // Latency byte is not stored, see R03
            end
            BBIOW_OFF_IO_STAT: begin
               if (pstrb[0]) begin
                  io_base_d = pwdata[BBIOW_IO_BASE_LSB +: 4]; // see R05
               end
               if (pstrb[1]) begin
                  io_lim_d = pwdata[BBIOW_IO_LIM_LSB +: 4]; // see R06
               end
            end
            BBIOW_OFF_IO_UPPER: begin
               if (pstrb[0]) begin
                  up_base_d[7:0] = pwdata[7:0]; // see R08
               end
               if (pstrb[1]) begin
                  up_base_d[15:8] = pwdata[15:8];
               end
               if (pstrb[2]) begin
                  up_lim_d[7:0] = pwdata[23:16]; // see R08
               end
               if (pstrb[3]) begin
                  up_lim_d[15:8] = pwdata[31:24];
               end
            end
            BBIOW_OFF_CTRL: begin
               if (pstrb[0]) begin
                  ctrl_d = pwdata[BBIOW_CTRL_PERR_EN +: 2];
               end
            end
            default: ctrl_d = ctrl_q;
         endcase
      end
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_bus_q <= BBIOW_BUS_RST;
         sub_bus_q <= BBIOW_BUS_RST;
         io_base_q <= BBIOW_IO_NIB_RST;
         io_lim_q <= BBIOW_IO_NIB_RST;
         up_base_q <= BBIOW_UPPER_RST;
         up_lim_q <= BBIOW_UPPER_RST;
         ctrl_q <= BBIOW_CTRL_RST;
      end else begin
         sec_bus_q <= sec_bus_d;
         sub_bus_q <= sub_bus_d;
         io_base_q <= io_base_d;
         io_lim_q <= io_lim_d;
         up_base_q <= up_base_d;
         up_lim_q <= up_lim_d;
         ctrl_q <= ctrl_d;
      end
   end

   // ------------------------------------------------------------
   // Error flags
   // ------------------------------------------------------------

   // Event sources in flag index order, with enables applied
   always_comb begin
      flag_set[0] = sec_parity_err_evt && // see R10 R11
         ctrl_q[BBIOW_CTRL_PERR_EN];
      flag_set[1] = sec_cpl_abort_sent_evt; // see R12
      flag_set[2] = sec_rx_cpl_abort_evt; // see R13
      flag_set[3] = sec_rx_cpl_ur_evt; // see R14
      flag_set[4] = err_msg_sent_evt && // see R15
         ctrl_q[BBIOW_CTRL_SYS_ERR_EN];
      flag_set[5] = sec_poisoned_rx_evt; // see R16
   end

   // Per flag: set wins over a write-one clear; read-only flags keep
   generate
      for (genvar g = 0; g < BBIOW_NFLAG; g++) begin : g_flag
         assign flag_clr[g] = wr_en && (paddr == BBIOW_OFF_IO_STAT) &&
            pstrb[BBIOW_STAT_BYTE] && pwdata[BBIOW_FLAG_POS[g]] &&
            BBIOW_FLAG_W1C[g]; // see R10 R15 R16 R19
         assign flag_d[g] = flag_set[g] || (flag_q[g] && !flag_clr[g]);
      end
   endgenerate

   // Flag registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= BBIOW_FLAG_RST;
      end else begin
         flag_q <= flag_d;
      end
   end

   // ------------------------------------------------------------
   // Forwarding and bus range decisions
   // ------------------------------------------------------------

   // Window comparison on the composed bounds
   bbiow_io_match u_io_match (
      .base_upper(up_base_q),
      .base_nib(io_base_q),
      .limit_upper(up_lim_q),
      .limit_nib(io_lim_q),
      .addr(io_req_addr),
      .hit(io_hit_raw)
   );

   // Results appear one cycle after the request
   always_comb begin
      io_fwd_valid_d = io_req_valid;
      io_fwd_hit_d = io_req_valid && io_hit_raw; // see R07 R18
      bus_valid_d = bus_req_valid;
      bus_in_d = bus_req_valid && (bus_req_num >= sec_bus_q) &&
         (bus_req_num <= sub_bus_q); // see R17
   end

   // Decision registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_fwd_valid_q <= 1'b0;
         io_fwd_hit_q <= 1'b0;
         bus_valid_q <= 1'b0;
         bus_in_q <= 1'b0;
      end else begin
         io_fwd_valid_q <= io_fwd_valid_d;
         io_fwd_hit_q <= io_fwd_hit_d;
         bus_valid_q <= bus_valid_d;
         bus_in_q <= bus_in_d;
      end
   end

   assign io_fwd_valid = io_fwd_valid_q;
   assign io_fwd_hit = io_fwd_hit_q;
   assign bus_range_valid = bus_valid_q;
   assign bus_in_range = bus_in_q;

endmodule : bbiow_top

`default_nettype wire

// ==== bbiow_chk.sv ====
/*
 * Checker for the bridge bus number and I/O window register bank:
 * register handshake timing, fixed read fields, check-port latency.
 * Assumes a bind from the bench top onto bbiow_top.
 */
`default_nettype none

module bbiow_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [bbiow_pkg::BBIOW_ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Check ports
   input wire logic io_req_valid,
   input wire logic io_fwd_valid,
   input wire logic bus_req_valid,
   input wire logic bus_range_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   import bbiow_pkg::*;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Good read answer and decoded address
   logic rd_ok;
   logic mapped;
   assign rd_ok = pready && !pwrite && !pslverr;
   assign mapped = paddr inside {BBIOW_OFF_BUS, BBIOW_OFF_IO_STAT,
                                 BBIOW_OFF_IO_UPPER, BBIOW_OFF_CTRL};

   // ------------------------------------------------------------
   // Handshake steps
   // ------------------------------------------------------------
   sequence s_first_access;
      psel && penable && !pready;
   endsequence
   sequence s_one_answer;
      pready ##1 !pready;
   endsequence

   a_answer_one_wait: assert property (
      s_first_access |=> s_one_answer)
      else $error("Access not answered after one wait cycle");
   a_idle_no_ready: assert property (!psel |=> !pready)
      else $error("Ready raised without a selected access");
   a_err_unmapped: assert property (pready |-> pslverr == !mapped)
      else $error("Error response does not match address decode");
   a_rdata_quiet: assert property (
      !pready |-> prdata == BBIOW_ZERO_WORD)
      else $error("Read data not zero outside a response");
   a_latency_zero: assert property (
      rd_ok && paddr == BBIOW_OFF_BUS |->
      prdata[31:24] == 8'h00 && prdata[7:0] == 8'h00)
      else $error("Latency or outside byte not zero");
   a_io_cap_bits: assert property (
      rd_ok && paddr == BBIOW_OFF_IO_STAT |->
      prdata[3:0] == 4'h1 && prdata[11:8] == 4'h1)
      else $error("I/O width indicator not one");
   a_status_fixed: assert property (
      rd_ok && paddr == BBIOW_OFF_IO_STAT |->
      prdata[23:16] == 8'h00 && prdata[26:25] == 2'h0)
      else $error("Fixed status bits not zero");
   a_io_check_lat: assert property (
      ##1 io_fwd_valid == $past(io_req_valid))
      else $error("I/O check answer not one cycle after request");
   a_bus_check_lat: assert property (
      ##1 bus_range_valid == $past(bus_req_valid))
      else $error("Bus check answer not one cycle after request");

endmodule : bbiow_chk

`default_nettype wire

// ==== test_bridge_bus_io_window_status.sv ====
/*
 * Self-checking bench for bbiow_top: reset values, bus numbers,
 * I/O window, error flags, unmapped access.
 * Assumes the design package and bbiow_chk are compiled first.
 */
`default_nettype none

module test_bridge_bus_io_window_status;
   timeunit 1ns;
   timeprecision 1ns;
   import bbiow_pkg::*;

   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, bus_req_num;
   logic [31:0] pwdata, prdata, io_req_addr, rd;
   logic [3:0] pstrb;
   logic [5:0] evt;
   logic io_req_valid, io_fwd_valid, io_fwd_hit, err;
   logic bus_req_valid, bus_range_valid, bus_in_range;
   int miscompares = 0;
   int tests_run = 0;
   int cyc = 0;

   bbiow_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sec_parity_err_evt(evt[0]), .sec_cpl_abort_sent_evt(evt[1]),
      .sec_rx_cpl_abort_evt(evt[2]), .sec_rx_cpl_ur_evt(evt[3]),
      .err_msg_sent_evt(evt[4]), .sec_poisoned_rx_evt(evt[5]),
      .io_req_valid(io_req_valid), .io_req_addr(io_req_addr),
      .io_fwd_valid(io_fwd_valid), .io_fwd_hit(io_fwd_hit),
      .bus_req_valid(bus_req_valid), .bus_req_num(bus_req_num),
      .bus_range_valid(bus_range_valid), .bus_in_range(bus_in_range));

   // Clock and hang guard
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         finish_test();
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   // One APB transfer; waits for ready with no bound of its own, only the hang guard stops it
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(rd, exp);
      chk({31'h0, err}, 32'h0);
   endtask : rd_chk

   // Requests an I/O or bus check and compares the registered answer
   task automatic port_chk(input logic io, input logic [31:0] a,
                           input logic exp);
      @(posedge pclk);
      io_req_valid <= io;
      bus_req_valid <= !io;
      io_req_addr <= a;
      bus_req_num <= a[7:0];
      @(posedge pclk);
      io_req_valid <= 1'b0;
      bus_req_valid <= 1'b0;
      @(posedge pclk);
      chk({31'h0, io ? io_fwd_hit : bus_in_range}, {31'h0, exp});
   endtask : port_chk

   task automatic pulse(input logic [5:0] m);
      @(posedge pclk);
      evt <= m;
      @(posedge pclk);
      evt <= 6'h00;
   endtask : pulse

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset_vals();
      rd_chk(BBIOW_OFF_BUS, 32'h0000_0000);
      rd_chk(BBIOW_OFF_IO_STAT, 32'h0000_0101);
      rd_chk(BBIOW_OFF_IO_UPPER, 32'h0000_0000);
      rd_chk(BBIOW_OFF_CTRL, 32'h0000_0000);
      port_chk(1'b1, 32'h0000_0fff, 1'b1);
      port_chk(1'b1, 32'h0000_1000, 1'b0);
   endtask : t_reset_vals

   task automatic t_bus_num();
      apb(1'b1, BBIOW_OFF_BUS, 32'hffff_ffff, 4'hf);
      rd_chk(BBIOW_OFF_BUS, 32'h00ff_ff00);
      apb(1'b1, BBIOW_OFF_BUS, 32'h0000_1000, 4'h2);
      rd_chk(BBIOW_OFF_BUS, 32'h00ff_1000);
      apb(1'b1, BBIOW_OFF_BUS, 32'h0020_0000, 4'h4);
      rd_chk(BBIOW_OFF_BUS, 32'h0020_1000);
      // Range edges of secondary 10h to highest 20h
      port_chk(1'b0, 32'h0f, 1'b0);
      port_chk(1'b0, 32'h10, 1'b1);
      port_chk(1'b0, 32'h20, 1'b1);
      port_chk(1'b0, 32'h21, 1'b0);
   endtask : t_bus_num

   task automatic t_io_window();
      apb(1'b1, BBIOW_OFF_IO_UPPER, 32'h0002_0001, 4'hf);
      apb(1'b1, BBIOW_OFF_IO_STAT, 32'h0000_a050, 4'h3);
      rd_chk(BBIOW_OFF_IO_STAT, 32'h0000_a151);
      rd_chk(BBIOW_OFF_IO_UPPER, 32'h0002_0001);
      // Window 0001_5000 to 0002_afff inclusive
      port_chk(1'b1, 32'h0001_4fff, 1'b0);
      port_chk(1'b1, 32'h0001_5000, 1'b1);
      port_chk(1'b1, 32'h0002_afff, 1'b1);
      port_chk(1'b1, 32'h0002_b000, 1'b0);
      port_chk(1'b1, 32'h0000_5000, 1'b0);
   endtask : t_io_window

   task automatic t_err_flags();
      pulse(6'h3f);
      rd_chk(BBIOW_OFF_IO_STAT, 32'hb800_a151);
      apb(1'b1, BBIOW_OFF_CTRL, 32'h0000_0003, 4'hf);
      rd_chk(BBIOW_OFF_CTRL, 32'h0000_0003);
      pulse(6'h11);
      rd_chk(BBIOW_OFF_IO_STAT, 32'hf900_a151);
      apb(1'b1, BBIOW_OFF_IO_STAT, 32'hff00_0000, 4'h8);
      rd_chk(BBIOW_OFF_IO_STAT, 32'h3800_a151);
   endtask : t_err_flags

   task automatic t_unmapped();
      apb(1'b1, 8'h20, 32'hffff_ffff, 4'hf);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 8'h20, 32'h0, 4'h0);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
      rd_chk(BBIOW_OFF_IO_STAT, 32'h3800_a151);
   endtask : t_unmapped

   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      evt = 6'h00;
      io_req_valid = 1'b0;
      io_req_addr = 32'h0;
      bus_req_valid = 1'b0;
      bus_req_num = 8'h00;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_vals();
      t_bus_num();
      t_io_window();
      t_err_flags();
      t_unmapped();
      finish_test();
   end

endmodule : test_bridge_bus_io_window_status

bind bbiow_top bbiow_chk u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .io_req_valid(io_req_valid), .io_fwd_valid(io_fwd_valid),
   .bus_req_valid(bus_req_valid), .bus_range_valid(bus_range_valid));

`default_nettype wire
